// file: sbs_pkg.sv
// Package of constants, types and helpers for the serial bus status logic
package sbs_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register bus geometry and byte offsets
	localparam int          SBS_ADR_W        = 4;
	localparam logic [3:0]  SBS_OFF_STATUS   = 4'h0;
	localparam logic [3:0]  SBS_OFF_CTRL     = 4'h4;
	localparam logic [3:0]  SBS_OFF_IRQ_STAT = 4'h8;
	localparam logic [3:0]  SBS_OFF_IRQ_MASK = 4'hC;

	////////////////////////////////////////////////////////////////////////////////
	// Status register field positions and reset value
	localparam int          SBS_ACK_BIT      = 15;
	localparam int          SBS_TXA_BIT      = 14;
	localparam int          SBS_BCL_BIT      = 10;
	localparam int          SBS_DA_BIT       = 5;
	localparam int          SBS_STOP_BIT     = 4;
	localparam logic [15:0] SBS_STATUS_RST   = 16'h0000;

	////////////////////////////////////////////////////////////////////////////////
	// Control register fields and reset value
	localparam int          SBS_SLV_EN_BIT   = 15;
	localparam int          SBS_OWN_ADR_W    = 7;
	localparam logic [15:0] SBS_CTRL_RST     = 16'h0000;

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt status and mask layout
	localparam int          SBS_IRQ_W        = 4;
	localparam int          SBS_IRQ_TXDONE   = 0;
	localparam int          SBS_IRQ_COLL     = 1;
	localparam int          SBS_IRQ_STOP     = 2;
	localparam int          SBS_IRQ_MATCH    = 3;
	localparam logic [3:0]  SBS_IRQ_RST      = 4'h0;

	////////////////////////////////////////////////////////////////////////////////
	// Bit counts of one transfer: eight data bits, then the acknowledge slot
	localparam logic [3:0]  SBS_LAST_DATA    = 4'h7;
	localparam logic [3:0]  SBS_ACK_SLOT     = 4'h8;
	localparam logic [3:0]  SBS_XFER_DONE    = 4'h9;

	////////////////////////////////////////////////////////////////////////////////
	// Bus events seen on the two wires, one cycle each, and the sampled data level
	typedef struct packed
	{
		logic start;
		logic stop;
		logic scl_rise;
		logic scl_fall;
		logic sda;
	} sbs_bus_ev_t;

	// Slave byte tracker states, Gray coded along idle, address, data
	typedef enum logic [1:0]
	{
		SLV_IDLE = 2'b00,
		SLV_ADDR = 2'b01,
		SLV_DATA = 2'b11,
		SLV_SKIP = 2'b10
	} sbs_slv_state_t;

	// Merge write data into a 16-bit register under the two low byte enables
	function automatic logic [15:0] sbs_lane_merge(input logic [15:0] old_val, input logic [15:0] new_val,
		input logic [1:0] sel);
		logic [15:0] res;
		res = old_val;
		if (sel[0])
			res[7:0] = new_val[7:0];
		if (sel[1])
			res[15:8] = new_val[15:8];
		return res;
	endfunction

endpackage

// file: sbs_bus_watch.sv
// Two-wire bus synchroniser and Start, Stop and clock edge detector
`timescale 1ns/1ps

module sbs_bus_watch
	import sbs_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Raw bus wires
	input  wire logic        scl_pin,
	input  wire logic        sda_pin,
	// Detected events
	output sbs_bus_ev_t      ev
);

	logic [1:0]  scl_sync_reg;
	logic [1:0]  sda_sync_reg;
	logic        scl_prev_reg;
	logic        sda_prev_reg;
	sbs_bus_ev_t ev_next;
	sbs_bus_ev_t ev_reg;

	// Event decode from the synchronised levels and their previous values
	always_comb
	begin
		ev_next          = '0;
		ev_next.sda      = sda_sync_reg[1];
		ev_next.start    = scl_sync_reg[1] && scl_prev_reg && sda_prev_reg && !sda_sync_reg[1];
		ev_next.stop     = scl_sync_reg[1] && scl_prev_reg && !sda_prev_reg && sda_sync_reg[1];
		ev_next.scl_rise = scl_sync_reg[1] && !scl_prev_reg;
		ev_next.scl_fall = !scl_sync_reg[1] && scl_prev_reg;
	end

	// Two-stage synchronisers, history and registered events
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			scl_sync_reg <= 2'h3;
			sda_sync_reg <= 2'h3;
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
			ev_reg       <= '0;
		end
		else
		begin
			scl_sync_reg <= {scl_sync_reg[0], scl_pin};
			sda_sync_reg <= {sda_sync_reg[0], sda_pin};
			scl_prev_reg <= scl_sync_reg[1];
			sda_prev_reg <= sda_sync_reg[1];
			ev_reg       <= ev_next;
		end
	end

	assign ev = ev_reg;

endmodule // sbs_bus_watch

// file: sbs_status.sv
// Status flag logic of a two-wire serial bus port with a Wishbone register slave
//
// Summary of operation
// - Transmit-active flag rises as soon as a master transmission starts.
// - Transmit-active stays high over eight bits and acknowledge, drops after acknowledge.
// - Collision during master operation sets a sticky flag cleared only by software.
// - Own slave address match clears the data-versus-address flag.
// - Each received slave data byte sets the data-versus-address flag.
// - Stop-seen flag reads one only when the last bus condition was Stop.
// - Every Start, Repeated Start or Stop updates the stop-seen flag.
`timescale 1ns/1ps

module sbs_status
	import sbs_pkg::*;
(
	// Clock and reset
	input  wire logic                 CLOCK,
	input  wire logic                 RESET,
	// Wishbone slave
	input  wire logic                 WB_CYC_I,
	input  wire logic                 WB_STB_I,
	input  wire logic                 WB_WE_I,
	input  wire logic [SBS_ADR_W-1:0] WB_ADR_I,
	input  wire logic [3:0]           WB_SEL_I,
	input  wire logic [31:0]          WB_DAT_I,
	output logic      [31:0]          WB_DAT_O,
	output logic                      WB_ACK_O,
	// Two-wire bus levels
	input  wire logic                 SCL_IN,
	input  wire logic                 SDA_IN,
	// Local master engine
	input  wire logic                 MTX_START,
	input  wire logic                 MTX_SDA_LEVEL,
	// Interrupt
	output logic                      IRQ
);

	////////////////////////////////////////////////////////////////////////////////
	// Bus event detector
	sbs_bus_ev_t ev;

	sbs_bus_watch u_watch
	(
		.clk     (CLOCK),
		.rst     (RESET),
		.scl_pin (SCL_IN),
		.sda_pin (SDA_IN),
		.ev      (ev)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Register bus access decode
	logic        ack_reg;
	logic        ack_next;
	logic [31:0] rdat_reg;
	logic [31:0] rdat_next;
	logic        acc;
	logic        wr_ctrl;
	logic        wr_mask;
	logic        bcl_clr;
	logic        irq_rd_clr;
	logic [15:0] status_word;
	logic [15:0] ctrl_reg;
	logic [15:0] ctrl_next;
	logic [SBS_IRQ_W-1:0] irq_stat_reg;
	logic [SBS_IRQ_W-1:0] irq_stat_next;
	logic [SBS_IRQ_W-1:0] irq_mask_reg;
	logic [SBS_IRQ_W-1:0] irq_mask_next;
	logic        irq_reg;
	logic        irq_next;

	// Access is taken on the edge where the answer is raised
	assign acc        = WB_CYC_I && WB_STB_I && !ack_reg;
	assign wr_ctrl    = acc && WB_WE_I && (WB_ADR_I == SBS_OFF_CTRL);
	assign wr_mask    = acc && WB_WE_I && (WB_ADR_I == SBS_OFF_IRQ_MASK) && WB_SEL_I[0];
	assign bcl_clr    = acc && WB_WE_I && (WB_ADR_I == SBS_OFF_STATUS) && WB_SEL_I[1]
		&& !WB_DAT_I[SBS_BCL_BIT];
	assign irq_rd_clr = acc && !WB_WE_I && (WB_ADR_I == SBS_OFF_IRQ_STAT);

	////////////////////////////////////////////////////////////////////////////////
	// Master transmit tracker
	logic       mtx_active_reg;
	logic       mtx_active_next;
	logic [3:0] mtx_cnt_reg;
	logic [3:0] mtx_cnt_next;
	logic       ack_resp_reg;
	logic       ack_resp_next;
	logic       bcl_reg;
	logic       bcl_next;
	logic       coll_evt;
	logic       ack_evt;
	logic       txdone_evt;

	// Our master released the wire in a data bit, yet the bus reads low
	assign coll_evt   = mtx_active_reg && ev.scl_rise && (mtx_cnt_reg < SBS_ACK_SLOT)
		&& MTX_SDA_LEVEL && !ev.sda;
	assign ack_evt    = mtx_active_reg && ev.scl_rise && (mtx_cnt_reg == SBS_ACK_SLOT);
	assign txdone_evt = mtx_active_reg && ev.scl_fall && (mtx_cnt_reg == SBS_XFER_DONE);

	// Next values of the transmit flag, bit count, acknowledge and collision
	always_comb
	begin
		mtx_active_next = mtx_active_reg;
		mtx_cnt_next    = mtx_cnt_reg;
		ack_resp_next   = ack_resp_reg;
		bcl_next        = bcl_reg;
		if (MTX_START)
		begin
			mtx_active_next = 1'b1;
			mtx_cnt_next    = 4'h0;
		end
		else if (coll_evt || ev.stop || txdone_evt)
			mtx_active_next = 1'b0;
		else if (mtx_active_reg && ev.scl_rise && (mtx_cnt_reg != SBS_XFER_DONE))
			mtx_cnt_next = mtx_cnt_reg + 4'h1;
		if (ack_evt)
			ack_resp_next = ev.sda;
		if (bcl_clr)
			bcl_next = 1'b0;
		if (coll_evt)
			bcl_next = 1'b1;
	end

	// Master tracker registers
	always_ff @(posedge CLOCK)
	begin
		if (RESET)
		begin
			mtx_active_reg <= 1'b0;
			mtx_cnt_reg    <= 4'h0;
			ack_resp_reg   <= 1'b0;
			bcl_reg        <= 1'b0;
		end
		else
		begin
			mtx_active_reg <= mtx_active_next;
			mtx_cnt_reg    <= mtx_cnt_next;
			ack_resp_reg   <= ack_resp_next;
			bcl_reg        <= bcl_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Slave byte tracker and stop-seen flag
	sbs_slv_state_t              slv_state_reg;
	sbs_slv_state_t              slv_state_next;
	logic [3:0]                  slv_cnt_reg;
	logic [3:0]                  slv_cnt_next;
	logic [SBS_OWN_ADR_W-1:0]    slv_sh_reg;
	logic [SBS_OWN_ADR_W-1:0]    slv_sh_next;
	logic                        da_reg;
	logic                        da_next;
	logic                        stop_seen_reg;
	logic                        stop_seen_next;
	logic                        match_evt;
	logic                        data_evt;
	logic                        byte_end;

	assign byte_end  = ev.scl_rise && (slv_cnt_reg == SBS_LAST_DATA);
	assign match_evt = (slv_state_reg == SLV_ADDR) && byte_end && ctrl_reg[SBS_SLV_EN_BIT]
		&& (slv_sh_reg == ctrl_reg[SBS_OWN_ADR_W-1:0]);
	assign data_evt  = (slv_state_reg == SLV_DATA) && byte_end;

	// Next values of the slave tracker
	always_comb
	begin
		slv_state_next = slv_state_reg;
		slv_cnt_next   = slv_cnt_reg;
		slv_sh_next    = slv_sh_reg;
		da_next        = da_reg;
		stop_seen_next = stop_seen_reg;
		if (ev.start)
		begin
			slv_state_next = SLV_ADDR;
			slv_cnt_next   = 4'h0;
			stop_seen_next = 1'b0;
		end
		else if (ev.stop)
		begin
			slv_state_next = SLV_IDLE;
			stop_seen_next = 1'b1;
		end
		else if (ev.scl_rise)
		begin
			slv_sh_next = {slv_sh_reg[SBS_OWN_ADR_W-2:0], ev.sda};
			unique case (slv_state_reg)
				SLV_IDLE:
					slv_cnt_next = 4'h0;
				SLV_ADDR:
				begin
					slv_cnt_next = slv_cnt_reg + 4'h1;
					if (byte_end)
					begin
						slv_state_next = match_evt ? SLV_DATA : SLV_SKIP;
						slv_cnt_next   = SBS_ACK_SLOT; // next rising edge is the acknowledge
						if (match_evt)
							da_next = 1'b0;
					end
				end
				SLV_DATA:
				begin
					slv_cnt_next = (slv_cnt_reg == SBS_ACK_SLOT) ? 4'h0 : slv_cnt_reg + 4'h1;
					if (data_evt)
						da_next = 1'b1;
				end
				SLV_SKIP:
					slv_cnt_next = 4'h0;
			endcase
		end
	end

	// Slave tracker registers
	always_ff @(posedge CLOCK)
	begin
		if (RESET)
		begin
			slv_state_reg <= SLV_IDLE;
			slv_cnt_reg   <= 4'h0;
			slv_sh_reg    <= '0;
			da_reg        <= 1'b0;
			stop_seen_reg <= 1'b0;
		end
		else
		begin
			slv_state_reg <= slv_state_next;
			slv_cnt_reg   <= slv_cnt_next;
			slv_sh_reg    <= slv_sh_next;
			da_reg        <= da_next;
			stop_seen_reg <= stop_seen_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register file, read data and interrupt
	logic [SBS_IRQ_W-1:0] irq_events;

	always_comb
	begin
		status_word               = SBS_STATUS_RST;
		status_word[SBS_ACK_BIT]  = ack_resp_reg;
		status_word[SBS_TXA_BIT]  = mtx_active_reg;
		status_word[SBS_BCL_BIT]  = bcl_reg;
		status_word[SBS_DA_BIT]   = da_reg;
		status_word[SBS_STOP_BIT] = stop_seen_reg;
		irq_events                 = '0;
		irq_events[SBS_IRQ_TXDONE] = txdone_evt;
		irq_events[SBS_IRQ_COLL]   = coll_evt;
		irq_events[SBS_IRQ_STOP]   = ev.stop;
		irq_events[SBS_IRQ_MATCH]  = match_evt;
	end

	// Bus answer, control, mask and sticky interrupt status; a new event wins over the read clear
	always_comb
	begin
		ack_next      = acc;
		rdat_next     = 32'h0000_0000;
		ctrl_next     = wr_ctrl ? sbs_lane_merge(ctrl_reg, WB_DAT_I[15:0], WB_SEL_I[1:0]) : ctrl_reg;
		irq_mask_next = wr_mask ? WB_DAT_I[SBS_IRQ_W-1:0] : irq_mask_reg;
		irq_stat_next = (irq_rd_clr ? '0 : irq_stat_reg) | irq_events;
		irq_next      = |(irq_stat_next & irq_mask_next);
		if (acc && !WB_WE_I)
		begin
			unique case (WB_ADR_I)
				SBS_OFF_STATUS:   rdat_next = {16'h0000, status_word};
				SBS_OFF_CTRL:     rdat_next = {16'h0000, ctrl_reg};
				SBS_OFF_IRQ_STAT: rdat_next = {28'h0000000, irq_stat_reg};
				SBS_OFF_IRQ_MASK: rdat_next = {28'h0000000, irq_mask_reg};
				default:          rdat_next = 32'h0000_0000; // Unmapped reads as zero
			endcase
		end
	end

	// Register file registers
	always_ff @(posedge CLOCK)
	begin
		if (RESET)
		begin
			ack_reg      <= 1'b0;
			rdat_reg     <= 32'h0000_0000;
			ctrl_reg     <= SBS_CTRL_RST;
			irq_mask_reg <= SBS_IRQ_RST;
			irq_stat_reg <= SBS_IRQ_RST;
			irq_reg      <= 1'b0;
		end
		else
		begin
			ack_reg      <= ack_next;
			rdat_reg     <= rdat_next;
			ctrl_reg     <= ctrl_next;
			irq_mask_reg <= irq_mask_next;
			irq_stat_reg <= irq_stat_next;
			irq_reg      <= irq_next;
		end
	end

	assign WB_ACK_O = ack_reg;
	assign WB_DAT_O = rdat_reg;
	assign IRQ      = irq_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Assertions and covers
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (RESET);

	a_txa_start_set: assert property (MTX_START |=> mtx_active_reg)
		else $error("Transmit-active flag did not rise after master start");

	a_txa_nine_bits: assert property ($fell(mtx_active_reg) && !$past(coll_evt) && !$past(ev.stop)
		|-> $past(mtx_cnt_reg) == 4'h9)
		else $error("Transmit-active flag dropped before nine clock pulses");

	a_txa_ack_end: assert property (txdone_evt && !MTX_START |=> !mtx_active_reg)
		else $error("Transmit-active flag held after acknowledge ended");

	a_bcl_coll_set: assert property (coll_evt |=> bcl_reg && !mtx_active_reg)
		else $error("Collision not flagged");

	a_bcl_sticky_hold: assert property (bcl_reg && !bcl_clr |=> bcl_reg)
		else $error("Collision flag cleared without software");

	a_da_addr_clear: assert property (match_evt |=> !da_reg ##0 slv_state_reg == SLV_DATA)
		else $error("Address match did not clear the data flag");

	a_da_data_set: assert property (data_evt |=> da_reg)
		else $error("Data byte did not set the data flag");

	a_stop_seen_set: assert property (ev.stop && !ev.start |=> stop_seen_reg && WB_ACK_O == $past(acc))
		else $error("Stop not recorded");

	a_stop_start_clr: assert property (ev.start |=> !stop_seen_reg)
		else $error("Start did not clear the stop flag");

	a_ack_capture: assert property (ack_evt |=> ack_resp_reg == $past(ev.sda))
		else $error("Acknowledge level not captured");

	c_master_byte: cover property (MTX_START ##[1:1000] txdone_evt);
	c_slave_data: cover property (match_evt ##[1:1000] data_evt);
	c_collision: cover property (coll_evt);
	c_irq_raised: cover property ($rose(IRQ));

endmodule // sbs_status

// file: sbs_bus_peer.sv
// Model of the other bus parties: bus clock source, Start, Stop and data bits
`timescale 1ns/1ps

module sbs_bus_peer
(
	// Clock
	input  wire logic clk,
	// Open-drain drives, one means released to the pull-up
	output logic      scl_drv,
	output logic      sda_drv
);
	// Half period of the 160 ns bus clock in system clocks
	localparam int HALF = 8;

	// Both lines released at time zero, so the pull-ups hold them high
	initial
	begin
		scl_drv = 1'b1;
		sda_drv = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Wait a number of system clock edges
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Start from idle, or repeated Start while the clock is low
	task automatic start_c();
		sda_drv <= 1'b1;
		wt(HALF);
		scl_drv <= 1'b1;
		wt(HALF);
		sda_drv <= 1'b0;
		wt(HALF);
		scl_drv <= 1'b0;
		wt(HALF);
	endtask

	// Stop: data rises while the clock is high, then the bus is left idle
	task automatic stop_c();
		sda_drv <= 1'b0;
		wt(HALF);
		scl_drv <= 1'b1;
		wt(HALF);
		sda_drv <= 1'b1;
		wt(HALF);
	endtask

	// One bit: data settles while the clock is low, small hold after the fall
	task automatic bit_c(input logic b);
		sda_drv <= b;
		wt(HALF);
		scl_drv <= 1'b1;
		wt(HALF);
		scl_drv <= 1'b0;
		wt(2);
	endtask

	// Eight bits, most significant first
	task automatic byte_c(input logic [7:0] v);
		for (int i = 7; i >= 0; i--)
			bit_c(v[i]);
	endtask
endmodule // sbs_bus_peer

// file: sbs_status_tb.sv
// Self-checking testbench of the serial bus status logic
`timescale 1ns/1ps

module sbs_status_tb;
	import sbs_pkg::*;

	// Clock, reset and register bus
	logic        clk = 1'b0;
	logic        rst;
	logic        cyc, stb, we, ack, irq;
	logic [3:0]  adr, sel;
	logic [31:0] wdat, rdat;
	// Bus wires and local master engine
	logic        scl_d, sda_d;
	logic        mtx_go, mtx_lvl;
	int          bad_count = 0, check_count = 0;

	// Clock of 100 MHz
	always #5 clk = ~clk;

	////////////////////////////////////////////////////////////////////////////////
	// Device and far-side model; the data wire is the AND of both open drains
	sbs_status dut_u (.CLOCK(clk), .RESET(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
		.WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
		.SCL_IN(scl_d), .SDA_IN(sda_d & mtx_lvl), .MTX_START(mtx_go), .MTX_SDA_LEVEL(mtx_lvl), .IRQ(irq));
	sbs_bus_peer peer_u (.clk(clk), .scl_drv(scl_d), .sda_drv(sda_d));

	////////////////////////////////////////////////////////////////////////////////
	// Verdict and end of run
	task automatic conclude();
		$display("Checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Compare a seen value against the expected one
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Classic Wishbone cycle: hold until ack is sampled, then release for a cycle
	task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= d;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ack !== 1'b1 && n < 50);
		if (n >= 50)
		begin
			bad_count++;
			conclude();
		end
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk);
	endtask

	// Pulse the local master start for one cycle
	task automatic go();
		mtx_go <= 1'b1;
		@(posedge clk);
		mtx_go <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Reset values and an unmapped read
	task automatic t_reset();
		logic [31:0] q;
		wb(1'b0, SBS_OFF_STATUS, 4'hF, 32'h0, q);
		check("status", q, {16'h0000, SBS_STATUS_RST});
		wb(1'b0, SBS_OFF_CTRL, 4'hF, 32'h0, q);
		check("ctrl", q, {16'h0000, SBS_CTRL_RST});
		wb(1'b0, 4'h2, 4'hF, 32'h0, q);
		check("unmapped", q, 32'h0);
		check("irq idle", 32'(irq), 32'h0);
	endtask

	// One master byte, acknowledge level given by the far side
	task automatic t_master(input logic ackl);
		logic [31:0] q;
		peer_u.start_c();
		go();
		// Local master releases the wire on the first run and pulls it low on the second
		mtx_lvl <= ackl;
		wb(1'b0, SBS_OFF_STATUS, 4'hF, 32'h0, q);
		check("tx begin", 32'(q[SBS_TXA_BIT]), 32'h1);
		peer_u.byte_c(8'hFF);
		mtx_lvl <= 1'b1;
		wb(1'b0, SBS_OFF_STATUS, 4'hF, 32'h0, q);
		check("tx hold", 32'(q[SBS_TXA_BIT]), 32'h1);
		check("tx no coll", 32'(q[SBS_BCL_BIT]), 32'h0);
		peer_u.bit_c(ackl);
		repeat (8) @(posedge clk);
		wb(1'b0, SBS_OFF_STATUS, 4'hF, 32'h0, q);
		check("tx end", 32'(q[SBS_TXA_BIT]), 32'h0);
		check("ack level", 32'(q[SBS_ACK_BIT]), 32'(ackl));
		peer_u.stop_c();
	endtask

	// Collision on the first data bit; sticky across read and Stop until cleared
	task automatic t_coll();
		logic [31:0] q;
		peer_u.start_c();
		go();
		peer_u.bit_c(1'b0);
		repeat (8) @(posedge clk);
		wb(1'b0, SBS_OFF_STATUS, 4'hF, 32'h0, q);
		check("coll set", 32'(q[SBS_BCL_BIT]), 32'h1);
		check("coll tx", 32'(q[SBS_TXA_BIT]), 32'h0);
		peer_u.stop_c();
		wb(1'b0, SBS_OFF_STATUS, 4'hF, 32'h0, q);
		check("coll sticky", 32'(q[SBS_BCL_BIT]), 32'h1);
		wb(1'b1, SBS_OFF_STATUS, 4'h2, 32'h0, q);
		wb(1'b0, SBS_OFF_STATUS, 4'hF, 32'h0, q);
		check("coll clear", 32'(q[SBS_BCL_BIT]), 32'h0);
	endtask

	// Slave: address, data, repeated Start with address, Stop
	task automatic t_slave();
		logic [31:0] q;
		wb(1'b1, SBS_OFF_CTRL, 4'h3, 32'h0000802A, q);
		peer_u.start_c();
		wb(1'b0, SBS_OFF_STATUS, 4'hF, 32'h0, q);
		check("start stop", 32'(q[SBS_STOP_BIT]), 32'h0);
		peer_u.byte_c(8'h54);
		peer_u.bit_c(1'b0);
		peer_u.byte_c(8'hA5);
		peer_u.bit_c(1'b0);
		wb(1'b0, SBS_OFF_STATUS, 4'hF, 32'h0, q);
		check("data byte", 32'(q[SBS_DA_BIT]), 32'h1);
		peer_u.start_c();
		peer_u.byte_c(8'h54);
		peer_u.bit_c(1'b0);
		wb(1'b0, SBS_OFF_STATUS, 4'hF, 32'h0, q);
		check("addr byte", 32'(q[SBS_DA_BIT]), 32'h0);
		check("rstart stop", 32'(q[SBS_STOP_BIT]), 32'h0);
		peer_u.stop_c();
		wb(1'b0, SBS_OFF_STATUS, 4'hF, 32'h0, q);
		check("stop seen", 32'(q[SBS_STOP_BIT]), 32'h1);
	endtask

	// Interrupt: masked event, unmask, read clears
	task automatic t_irq();
		logic [31:0] q;
		wb(1'b0, SBS_OFF_IRQ_STAT, 4'hF, 32'h0, q);
		check("irq all events", q, 32'h1 << SBS_IRQ_TXDONE | 32'h1 << SBS_IRQ_COLL | 32'h1 << SBS_IRQ_STOP
			| 32'h1 << SBS_IRQ_MATCH);
		peer_u.start_c();
		peer_u.stop_c();
		repeat (8) @(posedge clk);
		check("irq masked", 32'(irq), 32'h0);
		wb(1'b1, SBS_OFF_IRQ_MASK, 4'h1, 32'h1 << SBS_IRQ_STOP, q);
		repeat (2) @(posedge clk);
		check("irq raised", 32'(irq), 32'h1);
		wb(1'b0, SBS_OFF_IRQ_STAT, 4'hF, 32'h0, q);
		check("irq status", q, 32'h1 << SBS_IRQ_STOP);
		@(posedge clk);
		check("irq cleared", 32'(irq), 32'h0);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		rst     <= 1'b1;
		cyc     <= 1'b0;
		stb     <= 1'b0;
		we      <= 1'b0;
		adr     <= 4'h0;
		sel     <= 4'h0;
		wdat    <= 32'h0;
		mtx_go  <= 1'b0;
		mtx_lvl <= 1'b1;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		repeat (6) @(posedge clk);
		t_reset();
		t_master(1'b1);
		t_master(1'b0);
		t_coll();
		t_slave();
		t_irq();
		conclude();
	end

	// Hang guard
	initial
	begin
		repeat (100000) @(posedge clk);
		bad_count++;
		conclude();
	end
endmodule // sbs_status_tb
